// File: ufsm_fault_fsm.v
// Purpose: User-side layer 1 state machine F0..F7 with indications
// Assumes: Event inputs are pins, synchronised here; octet strobes are on mclk
// Notes:   Indications are one-cycle pulses; n rides with the error/correction pulse
//
// Behaviour
// RL1 - F0,F7 silent; F1,F2,F5 normal cells; F3 S-RDI+P-RDI; F4,F6 P-RDI only.
// RL2 - Power return in F0 enters F7 with no indication.
// RL3 - Power loss in F1..F7 goes F0 with EI0; from F1 also PH deactivate.
// RL4 - Normal cells in F2..F7 return to F1 with PH and MPH activate.
// RL5 - From F1 each fault issues PH deactivate and its error indications.
// RL6 - Fault states and F7 move without PH deactivate per the table.
// RL7 - Combined alarm enters F6; EI3/EI4 depend on the source state.
// RL8 - F3 ignores P-RDI, P-AIS, S-RDI and combined indications.
// RL9 - F4 ignores a further P-RDI and stays.
// RL10 - Error and correction indications carry n from 0 to 4.
// RL11 - MPH activate marks entry into the operational state.
// RL12 - PH deactivate when leaving operational state on fault or power loss.
// RL13 - Faults classed by location: FC1..FC4 map to n 1..4.
// RL14 - Remote defect is bit 1 of payload octet 30.
// RL15 - Path alarm is payload octet 2 all ones.
// RL16 - Same-cycle priority: power, LOS/LCD, combined, then single indications.
// RL17 - Reset starts in F0, quiet; power return enters F7.
`include "ufsm_map.vh"
`timescale 1ns/1ps
`default_nettype none

module ufsm_fault_fsm
(
  input  wire       mclk,
  input  wire       reset,
  input  wire       power_lost,
  input  wire       power_back,
  input  wire       los_in,
  input  wire       lcd_in,
  input  wire       normal_cells,
  input  wire       oct_valid,
  input  wire [4:0] oct_index,
  input  wire [7:0] oct_data,
  input  wire       oct_sec_cell,
  input  wire       oct_path_cell,
  output reg  [2:0] state_q,
  output reg  [1:0] tx_sel_q,
  output reg        ph_ai_q,
  output reg        ph_di_q,
  output reg        mph_ai_q,
  output reg        mph_ei_q,
  output reg  [4:0] mph_ei_n_q,
  output reg        mph_ci_q,
  output reg  [4:0] mph_ci_n_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages each
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  wire       s_rdi;
  wire       p_rdi;
  wire       p_ais;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_q <= 5'h0;
      sync2_q <= 5'h0;
    end
    else
    begin
      sync1_q <= {power_lost, power_back, los_in, lcd_in, normal_cells};
      sync2_q <= sync1_q;
    end
  end

  wire pwr_loss = sync2_q[4];
  wire pwr_back = sync2_q[3];
  wire sig_lost = sync2_q[2] | sync2_q[1];
  wire norm_rx  = sync2_q[0];

  ufsm_oam_decode ufsm_oam_decode_i
  (
    .mclk          (mclk),
    .reset         (reset),
    .oct_valid     (oct_valid),
    .oct_index     (oct_index),
    .oct_data      (oct_data),
    .oct_sec_cell  (oct_sec_cell),
    .oct_path_cell (oct_path_cell),
    .s_rdi_seen_q  (s_rdi),
    .p_rdi_seen_q  (p_rdi),
    .p_ais_seen_q  (p_ais)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit selection per state
  function [1:0] tx_of;
    input [2:0] st;
    begin
      case (st)
        `UFSM_F1, `UFSM_F2, `UFSM_F5: tx_of = `UFSM_TX_NORMAL;   // RL1
        `UFSM_F3:                     tx_of = `UFSM_TX_SP_RDI;   // RL1
        `UFSM_F4, `UFSM_F6:           tx_of = `UFSM_TX_P_RDI;    // RL1
        default:                      tx_of = `UFSM_TX_NONE;     // RL1
      endcase
    end
  endfunction

  // One-hot n mask; bit k set means n=k reported
  function [4:0] nbit;
    input [2:0] n;
    begin
      nbit = 5'h01 << n;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state and indications
  reg [2:0] state_d;
  reg       ph_ai_d;
  reg       ph_di_d;
  reg       mph_ai_d;
  reg [4:0] ei_d;
  reg [4:0] ci_d;
  wire      combo = p_ais & s_rdi & p_rdi;
  wire      sp    = p_rdi & s_rdi;
  wire      in_f1 = state_q == `UFSM_F1;

  always @*
  begin
    state_d  = state_q;
    ph_ai_d  = 1'b0;
    ph_di_d  = 1'b0;
    mph_ai_d = 1'b0;
    ei_d     = 5'h00;
    ci_d     = 5'h00;
    if (state_q == `UFSM_F0)
    begin
      if (pwr_back)
        state_d = `UFSM_F7;                                      // RL2 RL17
    end
    else if (pwr_loss)                                           // RL16
    begin
      state_d = `UFSM_F0;                                        // RL3
      ei_d    = nbit(`UFSM_N_POWER);                             // RL3 RL10
      ph_di_d = in_f1;                                           // RL3 RL12
    end
    else if (sig_lost)                                           // RL16
    begin
      if (state_q != `UFSM_F3)
      begin
        state_d = `UFSM_F3;                                      // RL6
        ei_d    = nbit(`UFSM_N_FC2);                             // RL13
        ph_di_d = in_f1;                                         // RL5 RL12
      end
    end
    else if (state_q == `UFSM_F3)
    begin
      if (norm_rx)                                               // RL8
      begin
        state_d  = `UFSM_F1;                                     // RL4
        ph_ai_d  = 1'b1;
        mph_ai_d = 1'b1;                                         // RL11
        ci_d     = nbit(`UFSM_N_FC2);                            // RL10
      end
    end
    else if (combo)                                              // RL16
    begin
      if (state_q != `UFSM_F6)                                   // RL7
      begin
        state_d = `UFSM_F6;                                      // RL7
        ph_di_d = in_f1;                                         // RL5
        if (state_q != `UFSM_F4)
          ei_d = ei_d | nbit(`UFSM_N_FC3);                       // RL7
        if (state_q != `UFSM_F5)
          ei_d = ei_d | nbit(`UFSM_N_FC4);                       // RL7
      end
    end
    else if (p_ais)
    begin
      if (state_q == `UFSM_F1 || state_q == `UFSM_F2 || state_q == `UFSM_F5 || state_q == `UFSM_F7)
      begin
        state_d = `UFSM_F4;                                      // RL6
        ei_d    = nbit(`UFSM_N_FC3);
        ph_di_d = in_f1;                                         // RL5
      end
    end
    else if (sp)
    begin
      if (state_q == `UFSM_F1 || state_q == `UFSM_F2 || state_q == `UFSM_F4 || state_q == `UFSM_F7)
      begin
        state_d = `UFSM_F5;                                      // RL6
        ei_d    = nbit(`UFSM_N_FC4);
        ph_di_d = in_f1;                                         // RL5
      end
    end
    else if (p_rdi)                                              // RL9
    begin
      if (state_q == `UFSM_F1 || state_q == `UFSM_F7)
      begin
        state_d = `UFSM_F2;                                      // RL5 RL6
        ei_d    = nbit(`UFSM_N_FC1);
        ph_di_d = in_f1;                                         // RL12
      end
    end
    else if (norm_rx && !in_f1)
    begin
      state_d  = `UFSM_F1;                                       // RL4
      ph_ai_d  = 1'b1;
      mph_ai_d = 1'b1;                                           // RL11
      case (state_q)
        `UFSM_F2: ci_d = nbit(`UFSM_N_FC1);
        `UFSM_F4: ci_d = nbit(`UFSM_N_FC3);
        `UFSM_F5: ci_d = nbit(`UFSM_N_FC4);
        `UFSM_F6: ci_d = nbit(`UFSM_N_FC3) | nbit(`UFSM_N_FC4);
        default:  ci_d = 5'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; reset holds F0 and quiet
  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_q    <= `UFSM_RESET_STATE;                           // RL17
      tx_sel_q   <= `UFSM_TX_NONE;
      ph_ai_q    <= 1'b0;
      ph_di_q    <= 1'b0;
      mph_ai_q   <= 1'b0;
      mph_ei_q   <= 1'b0;
      mph_ei_n_q <= 5'h00;
      mph_ci_q   <= 1'b0;
      mph_ci_n_q <= 5'h00;
    end
    else
    begin
      state_q    <= state_d;
      tx_sel_q   <= tx_of(state_d);                              // RL1
      ph_ai_q    <= ph_ai_d;
      ph_di_q    <= ph_di_d;
      mph_ai_q   <= mph_ai_d;
      mph_ei_q   <= |ei_d;
      mph_ei_n_q <= ei_d;                                        // RL10
      mph_ci_q   <= |ci_d;
      mph_ci_n_q <= ci_d;
    end
  end

endmodule // ufsm_fault_fsm

`default_nettype wire

// File: ufsm_fault_fsm_bench.sv
// Purpose: Directed walk through the user-side states
// Assumes: Pin events are one-cycle pulses
// Notes:   Indications are gathered over each step
`include "ufsm_map.vh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module ufsm_fault_fsm_bench;
  logic       mclk, reset, clr, send, oam_on, oct_valid, oct_sec_cell, oct_path_cell;
  logic [1:0] kind;
  logic [4:0] pins, oct_index, mph_ei_n_q, mph_ci_n_q;
  logic [7:0] oct_data;
  logic [15:0] seen;
  logic [2:0] state_q;
  logic [1:0] tx_sel_q;
  logic       ph_ai_q, ph_di_q, mph_ai_q, mph_ei_q, mph_ci_q;
  int         fail_count, n_compared, cyc;
  ufsm_fault_fsm ufsm_fault_fsm_i (.mclk(mclk), .reset(reset), .power_lost(pins[0]), .power_back(pins[1]),
    .los_in(pins[2]), .lcd_in(pins[3]), .normal_cells(pins[4]), .oct_valid(oct_valid), .oct_index(oct_index),
    .oct_data(oct_data), .oct_sec_cell(oct_sec_cell), .oct_path_cell(oct_path_cell), .state_q(state_q),
    .tx_sel_q(tx_sel_q), .ph_ai_q(ph_ai_q), .ph_di_q(ph_di_q), .mph_ai_q(mph_ai_q), .mph_ei_q(mph_ei_q),
    .mph_ei_n_q(mph_ei_n_q), .mph_ci_q(mph_ci_q), .mph_ci_n_q(mph_ci_n_q));
  ufsm_nt_model ufsm_nt_model_i (.mclk(mclk), .send(send), .kind(kind), .oam_on(oam_on),
    .oct_valid(oct_valid), .oct_index(oct_index), .oct_data(oct_data), .oct_sec_cell(oct_sec_cell),
    .oct_path_cell(oct_path_cell));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Sticky capture so pulse timing slips do not hide a missing indication
  always @(posedge mclk)
  begin
    seen <= clr ? 16'h0000 : seen | {3'h0, mph_ci_n_q & {5{mph_ci_q}}, ph_ai_q, ph_di_q, mph_ai_q,
                                     mph_ei_n_q & {5{mph_ei_q}}};
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      fail_count++;
      final_report;
    end
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] txof(input logic [2:0] s);
    if (s == `UFSM_F0 || s == `UFSM_F7) return `UFSM_TX_NONE;
    if (s == `UFSM_F3) return `UFSM_TX_SP_RDI;
    if (s == `UFSM_F4 || s == `UFSM_F6) return `UFSM_TX_P_RDI;
    return `UFSM_TX_NORMAL;
  endfunction
  // Flags: correction mask n=4..0, ph_ai, ph_di, mph_ai, then the error mask n=4..0
  // Octet code: bit 2 sets or clears; kind 0 path defect, 1 path alarm, 2 section defect
  task automatic step(input logic [4:0] p, input logic [2:0] o, input logic s, input logic [2:0] st,
                      input logic [15:0] fl);
    @(posedge mclk);
    pins <= p;
    kind <= o[1:0];
    oam_on <= o[2];
    send <= s;
    clr <= 1'b1;
    @(posedge mclk);
    pins <= 5'h00;
    send <= 1'b0;
    clr <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk({13'h0000, state_q}, {13'h0000, st});
    chk({14'h0000, tx_sel_q}, {14'h0000, txof(st)});
    chk(seen, fl);
  endtask
  initial
  begin
    {send, kind, oam_on, pins, fail_count, n_compared, cyc} = 0;
    reset = 1'b1;
    clr = 1'b1;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    step(5'h00, 3'h0, 1'h0, `UFSM_F0, 16'h0000);
    step(5'h02, 3'h0, 1'h0, `UFSM_F7, 16'h0000);
    step(5'h00, 3'h4, 1'h1, `UFSM_F2, 16'h0002);
    step(5'h00, 3'h5, 1'h1, `UFSM_F4, 16'h0008);
    step(5'h00, 3'h1, 1'h1, `UFSM_F4, 16'h0000);
    step(5'h00, 3'h5, 1'h1, `UFSM_F4, 16'h0000);
    step(5'h00, 3'h6, 1'h1, `UFSM_F6, 16'h0010);
    step(5'h00, 3'h6, 1'h1, `UFSM_F6, 16'h0000);
    step(5'h04, 3'h0, 1'h0, `UFSM_F3, 16'h0004);
    step(5'h00, 3'h5, 1'h1, `UFSM_F3, 16'h0000);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h04a0);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h0000);
    step(5'h00, 3'h6, 1'h1, `UFSM_F6, 16'h0058);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h18a0);
    step(5'h00, 3'h1, 1'h1, `UFSM_F5, 16'h0050);
    step(5'h00, 3'h5, 1'h1, `UFSM_F6, 16'h0008);
    step(5'h00, 3'h2, 1'h1, `UFSM_F6, 16'h0000);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h18a0);
    step(5'h00, 3'h0, 1'h1, `UFSM_F4, 16'h0048);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h08a0);
    step(5'h00, 3'h1, 1'h1, `UFSM_F1, 16'h0000);
    step(5'h00, 3'h4, 1'h1, `UFSM_F2, 16'h0042);
    step(5'h00, 3'h6, 1'h1, `UFSM_F5, 16'h0010);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h10a0);
    step(5'h08, 3'h0, 1'h0, `UFSM_F3, 16'h0044);
    step(5'h10, 3'h0, 1'h0, `UFSM_F1, 16'h04a0);
    step(5'h05, 3'h0, 1'h0, `UFSM_F0, 16'h0041);
    step(5'h04, 3'h0, 1'h0, `UFSM_F0, 16'h0000);
    step(5'h02, 3'h0, 1'h0, `UFSM_F7, 16'h0000);
    step(5'h01, 3'h0, 1'h0, `UFSM_F0, 16'h0001);
    step(5'h02, 3'h0, 1'h0, `UFSM_F7, 16'h0000);
    step(5'h00, 3'h5, 1'h1, `UFSM_F6, 16'h0018);
    final_report;
  end
endmodule // ufsm_fault_fsm_bench
`default_nettype wire

// File: ufsm_fault_fsm_sva.sv
// Purpose: Assertions on the user-side fault state machine
// Assumes: Pulses land in the cycle the state changes
// Notes:   Correction pulses judged only against activate
`include "ufsm_map.vh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module ufsm_fault_fsm_sva
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [2:0] state_q,
  input wire logic [1:0] tx_sel_q,
  input wire logic       ph_ai_q,
  input wire logic       ph_di_q,
  input wire logic       mph_ai_q,
  input wire logic       mph_ei_q,
  input wire logic [4:0] mph_ei_n_q,
  input wire logic       mph_ci_q,
  input wire logic [4:0] mph_ci_n_q
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (reset);
  // Tx register is loaded from the next state in step with the state; only settled states are judged
  function automatic logic [1:0] ufsm_tx(input logic [2:0] s);
    if (s == `UFSM_F0 || s == `UFSM_F7) return `UFSM_TX_NONE;
    if (s == `UFSM_F3) return `UFSM_TX_SP_RDI;
    if (s == `UFSM_F4 || s == `UFSM_F6) return `UFSM_TX_P_RDI;
    return `UFSM_TX_NORMAL;
  endfunction
  a_tx_by_state: assert property ($stable(state_q) |-> tx_sel_q == ufsm_tx(state_q))
    else $error("tx selection wrong");
  a_power_return: assert property ($past(state_q) == `UFSM_F0 && state_q != `UFSM_F0
    |-> state_q == `UFSM_F7 && !mph_ei_q && !ph_ai_q) else $error("bad exit from F0");
  a_power_loss: assert property (state_q == `UFSM_F0 && $past(state_q) != `UFSM_F0
    |-> mph_ei_q && mph_ei_n_q == 5'h01) else $error("no EI0 on power loss");
  a_deact_from_f1: assert property (ph_di_q
    |-> $past(state_q) == `UFSM_F1 && state_q != `UFSM_F1 && mph_ei_q) else $error("stray deactivate");
  a_activate_f1: assert property (ph_ai_q
    |-> state_q == `UFSM_F1 && $past(state_q) != `UFSM_F1 && mph_ai_q) else $error("stray activate");
  a_f3_ignores: assert property ($past(state_q) == `UFSM_F3 && state_q != `UFSM_F3
    |-> state_q == `UFSM_F0 || state_q == `UFSM_F1) else $error("F3 left on alarm");
  a_f4_keeps: assert property ($past(state_q) == `UFSM_F4 |-> state_q != `UFSM_F2)
    else $error("F4 took P-RDI");
  a_enter_f3: assert property (state_q == `UFSM_F3 && $past(state_q) != `UFSM_F3
    |-> mph_ei_q && mph_ei_n_q == 5'h04) else $error("no EI2 into F3");
  a_enter_f6: assert property (state_q == `UFSM_F6 && $past(state_q) != `UFSM_F6
    |-> mph_ei_q && mph_ei_n_q == ($past(state_q) == `UFSM_F4 ? 5'h10 :
                                   $past(state_q) == `UFSM_F5 ? 5'h08 : 5'h18))
    else $error("wrong EI into F6");
  a_corr_pair: assert property (mph_ci_q |-> ph_ai_q && mph_ci_n_q != 5'h00)
    else $error("stray correction");
  c_activate: cover property (ph_ai_q);
  c_f6: cover property (state_q == `UFSM_F6);
  c_deactivate: cover property (ph_di_q);
  c_f4: cover property (state_q == `UFSM_F4);
endmodule // ufsm_fault_fsm_sva
bind ufsm_fault_fsm ufsm_fault_fsm_sva ufsm_fault_fsm_sva_i (.mclk(mclk), .reset(reset), .state_q(state_q),
  .tx_sel_q(tx_sel_q), .ph_ai_q(ph_ai_q), .ph_di_q(ph_di_q), .mph_ai_q(mph_ai_q), .mph_ei_q(mph_ei_q),
  .mph_ei_n_q(mph_ei_n_q), .mph_ci_q(mph_ci_q), .mph_ci_n_q(mph_ci_n_q));
`default_nettype wire

// File: ufsm_map.vh
// Purpose: Constants for the user-side layer 1 fault state machine
// Assumes: Plain Verilog-2005 include
// Notes:   States, transmit selections, cell field positions
`ifndef UFSM_MAP_VH
`define UFSM_MAP_VH

`define UFSM_F0            3'h0
`define UFSM_F1            3'h1
`define UFSM_F2            3'h2
`define UFSM_F3            3'h3
`define UFSM_F4            3'h4
`define UFSM_F5            3'h5
`define UFSM_F6            3'h6
`define UFSM_F7            3'h7
`define UFSM_RESET_STATE   3'h0

`define UFSM_TX_NONE       2'h0
`define UFSM_TX_NORMAL     2'h1
`define UFSM_TX_SP_RDI     2'h2
`define UFSM_TX_P_RDI      2'h3

`define UFSM_N_POWER       3'h0
`define UFSM_N_FC1         3'h1
`define UFSM_N_FC2         3'h2
`define UFSM_N_FC3         3'h3
`define UFSM_N_FC4         3'h4

`define UFSM_RDI_OCTET     5'h1e
`define UFSM_RDI_BIT       3'h1
`define UFSM_AIS_OCTET     5'h02
`define UFSM_AIS_VALUE     8'hff

`endif

// File: ufsm_nt_model.sv
// Purpose: Network side sending path maintenance octets
// Assumes: One octet per strobe; kind 0 path defect, 1 path alarm, 2 section defect
// Notes:   Idle data toggles so stale values never match
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module ufsm_nt_model
(
  input  wire logic       mclk,
  input  wire logic       send,
  input  wire logic [1:0] kind,
  input  wire logic       oam_on,
  output var  logic       oct_valid,
  output var  logic [4:0] oct_index,
  output var  logic [7:0] oct_data,
  output var  logic       oct_sec_cell,
  output var  logic       oct_path_cell
);
  initial
  begin
    oct_valid = 1'h0;
    oct_index = 5'h00;
    oct_data = 8'h00;
    oct_sec_cell = 1'h0;
    oct_path_cell = 1'h0;
  end
  // Clearing values miss by one bit, so a sloppy decode shows up
  always @(posedge mclk)
  begin
    oct_valid <= send;
    oct_sec_cell <= send && kind == 2'h2;
    oct_path_cell <= send && kind != 2'h2;
    oct_index <= !send ? oct_index + 5'h01 : (kind == 2'h1 ? 5'h02 : 5'h1e);
    if (!send)
      oct_data <= ~oct_data;
    else if (kind == 2'h1)
      oct_data <= oam_on ? 8'hff : 8'h7f;
    else
      oct_data <= oam_on ? 8'h02 : 8'hfd;
  end
endmodule // ufsm_nt_model
`default_nettype wire

// File: ufsm_oam_decode.v
// Purpose: Decode remote defect and alarm bits from maintenance cell octets
// Assumes: Octet strobes come from logic on mclk
// Notes:   Levels held per indication; each update pulses every level that is set
`include "ufsm_map.vh"
`timescale 1ns/1ps
`default_nettype none

module ufsm_oam_decode
(
  input  wire       mclk,
  input  wire       reset,
  input  wire       oct_valid,
  input  wire [4:0] oct_index,
  input  wire [7:0] oct_data,
  input  wire       oct_sec_cell,
  input  wire       oct_path_cell,
  output reg        s_rdi_seen_q,
  output reg        p_rdi_seen_q,
  output reg        p_ais_seen_q
);

  // Levels persist so indications from separate cells can combine in one event
  wire rdi_bit;
  wire sec_rdi_oct;
  wire path_rdi_oct;
  wire path_ais_oct;
  wire any_oct;
  wire s_rdi_d;
  wire p_rdi_d;
  wire p_ais_d;
  reg  s_rdi_lvl_q;
  reg  p_rdi_lvl_q;
  reg  p_ais_lvl_q;

  assign rdi_bit      = oct_data[`UFSM_RDI_BIT];
  assign sec_rdi_oct  = oct_valid && oct_sec_cell && oct_index == `UFSM_RDI_OCTET;      // RL14
  assign path_rdi_oct = oct_valid && oct_path_cell && oct_index == `UFSM_RDI_OCTET;     // RL14
  assign path_ais_oct = oct_valid && oct_path_cell && oct_index == `UFSM_AIS_OCTET;     // RL15
  assign any_oct      = sec_rdi_oct | path_rdi_oct | path_ais_oct;
  assign s_rdi_d      = sec_rdi_oct ? rdi_bit : s_rdi_lvl_q;
  assign p_rdi_d      = path_rdi_oct ? rdi_bit : p_rdi_lvl_q;
  assign p_ais_d      = path_ais_oct ? oct_data == `UFSM_AIS_VALUE : p_ais_lvl_q;       // RL15

  always @(posedge mclk)
  begin
    if (reset)
    begin
      s_rdi_lvl_q  <= 1'b0;
      p_rdi_lvl_q  <= 1'b0;
      p_ais_lvl_q  <= 1'b0;
      s_rdi_seen_q <= 1'b0;
      p_rdi_seen_q <= 1'b0;
      p_ais_seen_q <= 1'b0;
    end
    else
    begin
      s_rdi_lvl_q  <= s_rdi_d;
      p_rdi_lvl_q  <= p_rdi_d;
      p_ais_lvl_q  <= p_ais_d;
      // Each update reports the full set; no update, no event
      s_rdi_seen_q <= any_oct & s_rdi_d;
      p_rdi_seen_q <= any_oct & p_rdi_d;
      p_ais_seen_q <= any_oct & p_ais_d;
    end
  end

endmodule // ufsm_oam_decode

`default_nettype wire
